// File: design/agfc_gain_loop.sv
/*
  Gain loop of one channel: steps the gain by one half-dB at a time under
  attack, release and hold intervals. Amplitude input is a sampled envelope
  from the same clock; tick is a one-cycle millisecond pulse.
*/
module agfc_gain_loop
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_tick,
  input  wire logic              i_run,
  input  wire agfc_pkg::agfc_cfg_t i_cfg,
  input  wire logic        [7:0] i_amp,
  output logic signed      [7:0] o_gain,
  output logic                   o_down,
  output logic                   o_up
);

  logic [4:0] atk_cnt;
  logic [4:0] rel_cnt;
  logic [4:0] hold_cnt;
  logic       was_high;

  function automatic logic signed [7:0] lo_bound(input logic comp);
    lo_bound = comp ? agfc_pkg::GAIN_MIN_COMP : agfc_pkg::GAIN_MIN_NOCOMP;
  endfunction

  function automatic logic signed [7:0] clampg(input logic signed [7:0] g,
                                              input logic comp);
    if (g < lo_bound(comp))
      clampg = lo_bound(comp);
    else if (g > agfc_pkg::GAIN_MAX_ALL)
      clampg = agfc_pkg::GAIN_MAX_ALL;
    else
      clampg = g;
  endfunction

  // Output level estimate: input envelope plus gain, 10 bits signed, no saturation
  wire logic signed [9:0] out_lvl = $signed({2'b00, i_amp}) +
                                    {{2{o_gain[7]}}, o_gain};
  // Target gain from ratio: excess below the limiter shifted by the ratio
  wire logic signed [9:0] deficit = $signed({2'b00, i_cfg.limiter}) - out_lvl;
  wire logic signed [9:0] comp_tgt = {{2{o_gain[7]}}, o_gain} +
                                     (deficit >>> i_cfg.ratio);
  wire logic gated    = i_amp < i_cfg.gate;
  wire logic too_loud = out_lvl > $signed({2'b00, i_cfg.limiter});
  wire logic want_up  = !too_loud && deficit > 10'sd1 &&
                        comp_tgt > {{2{o_gain[7]}}, o_gain} &&
                        o_gain < i_cfg.max_gain;
  wire logic atk_done = atk_cnt >= {1'b0, i_cfg.attack};
  wire logic rel_done = rel_cnt >= {1'b0, i_cfg.rel_time};
  wire logic hld_done = !was_high ||
                        hold_cnt >= {1'b0, i_cfg.hold};
  wire logic do_down  = i_run && i_cfg.loop_en && !gated && too_loud &&
                        atk_done;
  wire logic do_up    = i_run && i_cfg.loop_en && !gated && want_up &&
                        rel_done && hld_done;
  wire logic signed [7:0] next_gain =
    !i_run || !i_cfg.loop_en ? clampg(i_cfg.fixed_gain, i_cfg.comp_en) :
    do_down ? clampg(o_gain - agfc_pkg::GAIN_STEP, i_cfg.comp_en) :
    do_up   ? clampg(o_gain + agfc_pkg::GAIN_STEP, i_cfg.comp_en) :
    o_gain;

  function automatic logic [4:0] bump(input logic [4:0] c, input logic t);
    bump = (t && c != 5'h1F) ? c + 5'h01 : c;
  endfunction

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_gain   <= agfc_pkg::FIXED_RESET;
      atk_cnt  <= 5'h1F;
      rel_cnt  <= 5'h1F;
      hold_cnt <= 5'h00;
      was_high <= 1'b0;
      o_down   <= 1'b0;
      o_up     <= 1'b0;
    end
    else
    begin
      o_gain <= next_gain;
      o_down <= do_down;
      o_up   <= do_up;
      // Attack starts full so the first overload drops gain at once
      if (do_down || do_up)
      begin
        atk_cnt  <= 5'h00;
        rel_cnt  <= 5'h00;
        hold_cnt <= 5'h00;
        was_high <= do_down;
      end
      else
      begin
        atk_cnt  <= bump(atk_cnt, i_tick);
        rel_cnt  <= bump(rel_cnt, i_tick);
        hold_cnt <= bump(hold_cnt, i_tick);
      end
    end
  end

endmodule

// File: design/agfc_pkg.sv
/*
  Shared constants and types of the auto gain and fault control block:
  register offsets, field positions, reset values and the settings bundle.
  Assumes a single 200 MHz clock and an AHB-Lite master with 32-bit data.
*/
package agfc_pkg;

  localparam int unsigned CLK_MHZ = 200;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FAULT    = 8'h04;
  localparam logic [7:0] OFS_GAINCFG  = 8'h08;
  localparam logic [7:0] OFS_LEVELS   = 8'h0C;
  localparam logic [7:0] OFS_TIMES    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;

  // Control register fields
  localparam int unsigned BIT_SWS_L    = 0;
  localparam int unsigned BIT_SWS_R    = 1;
  localparam int unsigned BIT_LOOP_EN  = 2;
  localparam int unsigned BIT_COMP_EN  = 4;
  // Fault flags sit at bit 3 (left) and bit 4 (right) of the fault register
  localparam int unsigned BIT_FAULT_L  = 3;
  localparam int unsigned BIT_FAULT_R  = 4;

  // Gain in half-dB units, signed 8 bits
  localparam logic signed [7:0] GAIN_MIN_COMP   = 8'shC8; // -28 dB
  localparam logic signed [7:0] GAIN_MIN_NOCOMP = 8'sh00; // 0 dB
  localparam logic signed [7:0] GAIN_MAX_ALL    = 8'sh3C; // +30 dB
  localparam logic signed [7:0] GAIN_STEP       = 8'sh01; // 0.5 dB
  localparam logic signed [7:0] FIXED_RESET     = 8'sh0C; // +6 dB

  // Time fields count in units of one millisecond tick
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

  localparam logic [15:0] TIMES_RESET = 16'h1421;
  localparam logic [31:0] LEVEL_RESET = 32'h0008_1A40;

  // Interrupt status bits
  localparam int unsigned IRQ_FAULT  = 0;
  localparam int unsigned IRQ_GDOWN  = 1;
  localparam int unsigned IRQ_GUP    = 2;
  localparam int unsigned IRQ_W      = 3;

  typedef enum logic [1:0] {
    CR_1TO1 = 2'b00,
    CR_2TO1 = 2'b01,
    CR_4TO1 = 2'b10,
    CR_8TO1 = 2'b11
  } agfc_ratio_t;

  typedef struct packed {
    logic               loop_en;
    logic               comp_en;
    agfc_ratio_t        ratio;
    logic signed [7:0]  fixed_gain;
    logic signed [7:0]  max_gain;
    logic        [7:0]  limiter;
    logic        [7:0]  gate;
    logic        [3:0]  attack;
    logic        [3:0]  rel_time;
    logic        [3:0]  hold;
  } agfc_cfg_t;

  typedef struct packed {
    logic        [7:0]  amp_in;
    logic               sc;
  } agfc_sense_t;

endpackage

// File: design/agfc_sync.sv
/*
  Three-stage synchroniser for a level from outside the clock domain.
  The output changes only once the second and third stages agree.
*/
module agfc_sync
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        o_level <= s3;
    end
  end

endmodule

// File: design/agfc_top.sv
/*
  Auto gain and fault control: AHB-Lite register slave, two gain loops,
  short-circuit latch with reduced duty-cycle mode, interrupts.
  Assumes short-circuit and shutdown pins are asynchronous, amplitude
  envelopes arrive on this clock, and hready is this slave's hreadyout.
*/
// Local design decisions: the register offsets and register access over AHB-Lite.
module agfc_top
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_shutdown_pin_n,
  input  wire logic        i_sc_left,
  input  wire logic        i_sc_right,
  input  wire logic  [7:0] i_amp_left,
  input  wire logic  [7:0] i_amp_right,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic  [1:0] htrans,
  input  wire logic        hwrite,
  input  wire logic  [2:0] hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic       [7:0] o_gain_left,
  output logic       [7:0] o_gain_right,
  output logic             o_enable_left,
  output logic             o_enable_right,
  output logic             o_low_duty_left,
  output logic             o_low_duty_right,
  output logic             o_irq
);

  agfc_pkg::agfc_cfg_t cfg;
  logic        sws_l;
  logic        sws_r;
  logic        fault_l;
  logic        fault_r;
  logic        low_l;
  logic        low_r;
  logic [agfc_pkg::IRQ_W-1:0] irq_stat;
  logic [agfc_pkg::IRQ_W-1:0] irq_en;
  logic        wr_pend;
  logic  [7:0] wr_addr;
  logic [31:0] tick_cnt;
  logic        tick;
  logic        sdn_pin_n;
  logic        sc_l;
  logic        sc_r;
  logic        down_l;
  logic        down_r;
  logic        up_l;
  logic        up_r;
  logic signed [7:0] gain_l;
  logic signed [7:0] gain_r;

  agfc_sync u_sync_sdn
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_shutdown_pin_n),
    .o_level   (sdn_pin_n)
  );

  agfc_sync u_sync_scl
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_sc_left),
    .o_level   (sc_l)
  );

  agfc_sync u_sync_scr
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_sc_right),
    .o_level   (sc_r)
  );

  // Channel runs only with pin high and its own software shutdown clear
  wire logic run_l = sdn_pin_n && !sws_l;
  wire logic run_r = sdn_pin_n && !sws_r;

  agfc_gain_loop u_loop_l
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (tick),
    .i_run     (run_l),
    .i_cfg     (cfg),
    .i_amp     (i_amp_left),
    .o_gain    (gain_l),
    .o_down    (down_l),
    .o_up      (up_l)
  );

  agfc_gain_loop u_loop_r
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (tick),
    .i_run     (run_r),
    .i_cfg     (cfg),
    .i_amp     (i_amp_right),
    .o_gain    (gain_r),
    .o_down    (down_r),
    .o_up      (up_r)
  );

  // Bus decode; writes complete in the data phase, reads answer directly
  wire logic addr_ok = htrans[1] && hsel && hready;
  wire logic wr_req  = addr_ok && hwrite;
  wire logic rd_req  = addr_ok && !hwrite;
  wire logic wr_now  = wr_pend;
  wire logic wr_ctrl  = wr_now && wr_addr == agfc_pkg::OFS_CTRL;
  wire logic wr_fault = wr_now && wr_addr == agfc_pkg::OFS_FAULT;
  wire logic wr_gcfg  = wr_now && wr_addr == agfc_pkg::OFS_GAINCFG;
  wire logic wr_lvl   = wr_now && wr_addr == agfc_pkg::OFS_LEVELS;
  wire logic wr_tim   = wr_now && wr_addr == agfc_pkg::OFS_TIMES;
  wire logic wr_ien   = wr_now && wr_addr == agfc_pkg::OFS_IRQ_EN;
  wire logic wr_iclr  = wr_now && wr_addr == agfc_pkg::OFS_IRQ_CLR;

  wire logic clr_fl = wr_fault && hwdata[agfc_pkg::BIT_FAULT_L];
  wire logic clr_fr = wr_fault && hwdata[agfc_pkg::BIT_FAULT_R];

  wire logic [agfc_pkg::IRQ_W-1:0] irq_evt =
    {up_l | up_r, down_l | down_r, (sc_l & !fault_l) | (sc_r & !fault_r)};
  wire logic [agfc_pkg::IRQ_W-1:0] iclr_mask =
    wr_iclr ? hwdata[agfc_pkg::IRQ_W-1:0] : {agfc_pkg::IRQ_W{1'b0}};

  // Fixed gain outside the allowed range is clipped when written
  wire logic signed [7:0] wfix = hwdata[7:0];
  wire logic signed [7:0] lo_fix = hwdata[agfc_pkg::BIT_COMP_EN + 8] ?
    agfc_pkg::GAIN_MIN_COMP : agfc_pkg::GAIN_MIN_NOCOMP;
  wire logic signed [7:0] next_fixed =
    wfix < lo_fix ? lo_fix :
    wfix > agfc_pkg::GAIN_MAX_ALL ? agfc_pkg::GAIN_MAX_ALL : wfix;

  wire logic [7:0] addr_rd = haddr[7:0];
  wire logic [31:0] rd_mux =
    addr_rd == agfc_pkg::OFS_CTRL ?
      {27'h0, cfg.comp_en, 1'b0, cfg.loop_en, sws_r, sws_l} :
    addr_rd == agfc_pkg::OFS_FAULT ?
      {27'h0, fault_r, fault_l, 3'h0} :
    addr_rd == agfc_pkg::OFS_GAINCFG ?
      {6'h0, cfg.ratio, cfg.max_gain, 8'h00, cfg.fixed_gain} :
    addr_rd == agfc_pkg::OFS_LEVELS ?
      {16'h0, cfg.gate, cfg.limiter} :
    addr_rd == agfc_pkg::OFS_TIMES ?
      {20'h0, cfg.hold, cfg.rel_time, cfg.attack} :
    addr_rd == agfc_pkg::OFS_STATUS ?
      {14'h0, low_r, low_l, gain_r, gain_l} :
    addr_rd == agfc_pkg::OFS_IRQ_STAT ? {29'h0, irq_stat} :
    addr_rd == agfc_pkg::OFS_IRQ_EN ? {29'h0, irq_en} : 32'h0000_0000;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= wr_req;
      if (wr_req)
        wr_addr <= haddr[7:0];
      if (rd_req)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sws_l       <= 1'b0;
      sws_r       <= 1'b0;
      cfg.loop_en <= 1'b1;
      cfg.comp_en <= 1'b1;
      cfg.ratio   <= agfc_pkg::CR_4TO1;
      cfg.fixed_gain <= agfc_pkg::FIXED_RESET;
      cfg.max_gain   <= agfc_pkg::GAIN_MAX_ALL;
      {cfg.gate, cfg.limiter} <= agfc_pkg::LEVEL_RESET[15:0];
      {cfg.hold, cfg.rel_time, cfg.attack} <= agfc_pkg::TIMES_RESET[11:0];
      irq_en      <= {agfc_pkg::IRQ_W{1'b0}};
    end
    else
    begin
      if (wr_ctrl)
      begin
        sws_l       <= hwdata[agfc_pkg::BIT_SWS_L];
        sws_r       <= hwdata[agfc_pkg::BIT_SWS_R];
        cfg.loop_en <= hwdata[agfc_pkg::BIT_LOOP_EN];
        cfg.comp_en <= hwdata[agfc_pkg::BIT_COMP_EN];
      end
      if (wr_gcfg)
      begin
        cfg.fixed_gain <= next_fixed;
        cfg.max_gain   <= hwdata[23:16];
        cfg.ratio      <= agfc_pkg::agfc_ratio_t'(hwdata[25:24]);
      end
      if (wr_lvl)
        {cfg.gate, cfg.limiter} <= hwdata[15:0];
      if (wr_tim)
        {cfg.hold, cfg.rel_time, cfg.attack} <= hwdata[11:0];
      if (wr_ien)
        irq_en <= hwdata[agfc_pkg::IRQ_W-1:0];
    end
  end

  // Fault and low-duty latches; a new event wins over a clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      fault_l  <= 1'b0;
      fault_r  <= 1'b0;
      low_l    <= 1'b0;
      low_r    <= 1'b0;
      irq_stat <= {agfc_pkg::IRQ_W{1'b0}};
    end
    else
    begin
      fault_l <= sc_l | (fault_l & !clr_fl);
      fault_r <= sc_r | (fault_r & !clr_fr);
      low_l   <= sc_l | (low_l & run_l);
      low_r   <= sc_r | (low_r & run_r);
      irq_stat <= irq_evt | (irq_stat & ~iclr_mask);
    end
  end

  // Millisecond tick shared by both loops' interval timers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end
    else
    begin
      tick <= tick_cnt == 32'(agfc_pkg::TICK_CYCLES - 1);
      if (tick_cnt == 32'(agfc_pkg::TICK_CYCLES - 1))
        tick_cnt <= 32'h0000_0000;
      else
        tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign o_gain_left      = gain_l;
  assign o_gain_right     = gain_r;
  assign o_enable_left    = run_l;
  assign o_enable_right   = run_r;
  assign o_low_duty_left  = low_l;
  assign o_low_duty_right = low_r;
  assign o_irq            = |(irq_stat & irq_en);

endmodule

// File: testbench/agfc_bench.sv
/*
  Self-checking bench of agfc_top: register table, fixed gain clipping,
  short-circuit fault, interrupts, software and pin shutdown.
  Assumes the host model on the bus and a 200 MHz clock.
*/
module agfc_bench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic wr; logic [7:0] wa; logic [31:0] wd;
    logic [7:0] ra; logic [31:0] mask; logic [31:0] exp;
  } agfc_row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pin_n = 1'b1;
  logic        sc_l = 1'b0;
  logic        sc_r = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic  [1:0] htrans;
  logic  [2:0] hsize;
  logic  [7:0] gain_l, gain_r;
  logic        en_l, en_r, low_l, low_r;
  int          err_total = 0;
  int          checked = 0;
  agfc_row_t   rows [14] = '{
    '{1'b0, 8'h00, 32'h0, 8'h00, 32'h17, 32'h14},
    '{1'b0, 8'h00, 32'h0, 8'h10, 32'hFFF, 32'h421},
    '{1'b0, 8'h00, 32'h0, 8'h0C, 32'hFFFF, 32'h1A40},
    '{1'b0, 8'h00, 32'h0, 8'h08, 32'h03FF00FF, 32'h023C000C},
    '{1'b0, 8'h00, 32'h0, 8'h14, 32'h3FFFF, 32'h0C0C},
    '{1'b1, 8'h00, 32'h10, 8'h00, 32'h17, 32'h10},
    '{1'b1, 8'h08, 32'h3C10C4, 8'h14, 32'hFF, 32'hC8},
    '{1'b1, 8'h08, 32'h3C00C4, 8'h14, 32'hFF, 32'h00},
    '{1'b1, 8'h08, 32'h3C1046, 8'h14, 32'hFF, 32'h3C},
    '{1'b1, 8'h08, 32'h3C10D0, 8'h14, 32'hFFFF, 32'hD0D0},
    '{1'b1, 8'h0C, 32'h2030, 8'h0C, 32'hFFFF, 32'h2030},
    '{1'b1, 8'h10, 32'hABC, 8'h10, 32'hFFF, 32'hABC},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 8'h40, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 8'h18, 32'h7, 8'h18, 32'h7, 32'h0}};

  always #2.5 clk = ~clk;

  agfc_host_model u_host (.i_ref_clk(clk), .i_hready(hreadyout),
    .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
    .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

  agfc_top u_dut (.i_ref_clk(clk), .i_rst(rst), .i_shutdown_pin_n(pin_n),
    .i_sc_left(sc_l), .i_sc_right(sc_r), .i_amp_left(8'h00),
    .i_amp_right(8'h00), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .o_gain_left(gain_l), .o_gain_right(gain_r), .o_enable_left(en_l),
    .o_enable_right(en_r), .o_low_duty_left(low_l),
    .o_low_duty_right(low_r), .o_irq(irq));

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd);
    wait_cyc(2);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0, rd);
    chk(nm, exp, rd & m);
  endtask

  task automatic give_verdict;
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A normal run takes well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial
  begin
    wait_cyc(5);
    rst <= 1'b0;
    wait_cyc(8);
    chk("reset gain", 32'h0C, {24'h0, gain_l});
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].wa, rows[i].wd);
      rdchk($sformatf("row %0d", i), rows[i].ra, rows[i].mask, rows[i].exp);
    end
    @(posedge clk);
    sc_l <= 1'b1;
    wait_cyc(10);
    sc_l <= 1'b0;
    wait_cyc(8);
    chk("low duty left", 32'h1, {31'h0, low_l});
    chk("low duty right", 32'h0, {31'h0, low_r});
    rdchk("fault set", 8'h04, 32'h18, 32'h08);
    wait_cyc(20);
    rdchk("fault kept", 8'h04, 32'h18, 32'h08);
    wr(8'h1C, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(8'h1C, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h20, 32'h1);
    rdchk("irq cleared", 8'h18, 32'h1, 32'h0);
    wr(8'h04, 32'h08);
    rdchk("fault cleared", 8'h04, 32'h18, 32'h0);
    chk("duty kept", 32'h1, {31'h0, low_l});
    wr(8'h00, 32'h11);
    chk("enable left", 32'h0, {31'h0, en_l});
    chk("enable right", 32'h1, {31'h0, en_r});
    chk("duty released", 32'h0, {31'h0, low_l});
    wr(8'h08, 32'h3C1020);
    wr(8'h00, 32'h14);
    chk("start gain", 32'h20, {24'h0, gain_l});
    wait_cyc(20);
    chk("gated gain", 32'h20, {24'h0, gain_l});
    @(posedge clk);
    sc_r <= 1'b1;
    wait_cyc(10);
    sc_r <= 1'b0;
    wait_cyc(8);
    chk("low duty right", 32'h1, {31'h0, low_r});
    @(posedge clk);
    pin_n <= 1'b0;
    wait_cyc(10);
    chk("pin stop", 32'h0, {31'h0, en_r});
    chk("pin duty", 32'h0, {31'h0, low_r});
    @(posedge clk);
    pin_n <= 1'b1;
    wait_cyc(10);
    chk("pin run", 32'h1, {31'h0, en_r});
    give_verdict();
  end
endmodule

// File: testbench/agfc_host_model.sv
/*
  Host controller model: AHB-Lite master doing single word transfers.
  Assumes hready is the slave's hreadyout; the bench calls xfer.
*/
module agfc_host_model
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic       [1:0] o_htrans,
  output logic             o_hwrite,
  output logic       [2:0] o_hsize,
  output logic      [31:0] o_hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_hsel   = 1'b0;
    o_haddr  = 32'h0;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize  = 3'h2;
    o_hwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge i_ref_clk);
    o_hsel   <= 1'b1;
    o_htrans <= 2'b10;
    o_haddr  <= {24'h0, addr};
    o_hwrite <= wr; // Faults and shutdown are cleared by writes
    @(posedge i_ref_clk);
    while (i_hready !== 1'b1)
      @(posedge i_ref_clk);
    o_hsel   <= 1'b0;
    o_htrans <= 2'b00;
    o_hwdata <= wdata;
    @(posedge i_ref_clk);
    while (i_hready !== 1'b1)
      @(posedge i_ref_clk);
    rdata = i_hrdata;
    // Released data must not look like a stale valid word
    o_hwdata <= ~wdata;
  endtask
endmodule

// File: testbench/agfc_top_asserts.sv
/*
  Checker for agfc_top: bus response, short-circuit duty mode, gain steps.
  Assumes one clock, synchronous reset and 3-stage pin synchronisers.
*/
module agfc_checker
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sc_left,
  input  wire logic       hsel,
  input  wire logic [1:0] htrans,
  input  wire logic       hwrite,
  input  wire logic       hreadyout,
  input  wire logic       hresp,
  input  wire logic [7:0] o_gain_left,
  input  wire logic       o_enable_left,
  input  wire logic       o_low_duty_left
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  logic [3:0]  quiet;
  logic [7:0]  prev_gain;
  logic        prev_en;
  logic [10:0] since_dec;
  logic [10:0] since_inc;
  // Writes may load a new fixed gain, so steps count only once bus is quiet
  wire         wr_seen = hsel && htrans[1] && hwrite;
  wire         settled = quiet > 4'h4 && o_enable_left && prev_en;
  wire   [7:0] gdiff   = o_gain_left - prev_gain;
  wire         chg     = settled && gdiff != 8'h00;
  wire         dec     = chg && gdiff[7];
  wire         inc     = chg && !gdiff[7];

  always_ff @(posedge i_ref_clk)
  begin
    prev_gain <= o_gain_left;
    if (i_rst)
    begin
      quiet     <= 4'h0;
      prev_en   <= 1'b0;
      since_dec <= 11'h7FF;
      since_inc <= 11'h7FF;
    end
    else
    begin
      quiet     <= wr_seen ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      prev_en   <= o_enable_left;
      since_dec <= dec ? 11'h000 : since_dec + {10'h0, since_dec != 11'h7FF};
      since_inc <= inc ? 11'h000 : since_inc + {10'h0, since_inc != 11'h7FF};
    end
  end

  bus_ready_a: assert property (hreadyout)
    else $error("hreadyout low");
  bus_okay_a: assert property (!hresp)
    else $error("hresp not OKAY");
  sc_duty_a: assert property ((i_sc_left && o_enable_left)[*6] |-> o_low_duty_left)
    else $error("short circuit did not set low duty");
  duty_hold_a: assert property (o_low_duty_left && o_enable_left |=> o_low_duty_left)
    else $error("low duty left while running");
  duty_clear_a: assert property ((!o_enable_left && !i_sc_left)[*6] |-> !o_low_duty_left)
    else $error("low duty kept in shutdown");
  gain_step_a: assert property (chg |-> gdiff == 8'h01 || gdiff == 8'hFF)
    else $error("gain step not one unit");
  attack_gap_a: assert property (dec |-> since_dec > 11'h3E8)
    else $error("decrements too close");
  release_gap_a: assert property (inc |-> since_inc > 11'h3E8)
    else $error("increments too close");

  cover property (o_low_duty_left);
  cover property (!o_enable_left ##1 o_enable_left);
  cover property (chg);
endmodule

bind agfc_top agfc_checker u_chk (.i_ref_clk, .i_rst, .i_sc_left, .hsel,
  .htrans, .hwrite, .hreadyout, .hresp, .o_gain_left, .o_enable_left,
  .o_low_duty_left);
